// ===== css_pkg.sv
// Package for the subtract, swap and exclusive-OR execution slice
package css_pkg;
    // APB map, byte addresses
    localparam int CSS_ADDR_W = 12;
    localparam logic [11:0] CSS_OFS_CMD = 12'h000;
    localparam logic [11:0] CSS_OFS_ACC = 12'h004;
    localparam logic [11:0] CSS_OFS_STATUS = 12'h008;
    localparam logic [11:0] CSS_OFS_DIR_A = 12'h00C;
    localparam logic [11:0] CSS_OFS_DIR_B = 12'h010;
    localparam logic [11:0] CSS_OFS_DIR_C = 12'h014;
    localparam logic [11:0] CSS_OFS_WDOG = 12'h018;
    localparam logic [11:0] CSS_OFS_FILE_BASE = 12'h200;
    localparam logic [2:0] CSS_FILE_PAGE = 3'h1;
    localparam int CSS_FILE_DEPTH = 128;

    // Command word fields
    localparam int CSS_CMD_OP_LSB = 0;
    localparam int CSS_CMD_ARG_LSB = 8;
    localparam int CSS_CMD_DEST_BIT = 16;

    // Status bit positions
    localparam int CSS_ST_C = 0;
    localparam int CSS_ST_DC = 1;
    localparam int CSS_ST_Z = 2;
    localparam int CSS_ST_PD = 3;
    localparam int CSS_ST_TO = 4;

    // Reset values
    localparam logic [7:0] CSS_RST_ACC = 8'h00;
    localparam logic [4:0] CSS_RST_STATUS = 5'h18;
    localparam logic [7:0] CSS_RST_DIR = 8'hFF;
    localparam logic [7:0] CSS_RST_FILE = 8'h00;
    localparam logic [7:0] CSS_WDOG_CLEAR = 8'h00;
    localparam logic [7:0] CSS_PRESCALE_CLEAR = 8'h00;

    // Direction register selectors
    localparam logic [7:0] CSS_DIR_SEL_A = 8'h05;
    localparam logic [7:0] CSS_DIR_SEL_B = 8'h06;
    localparam logic [7:0] CSS_DIR_SEL_C = 8'h07;

    // Operation codes
    typedef enum logic [3:0] {
        CSS_OP_NOP = 4'h0,
        CSS_OP_ENTER_POWERDOWN = 4'h1,
        CSS_OP_SUB_ACC_FROM_LITERAL = 4'h2,
        CSS_OP_SUB_ACC_FROM_FILE = 4'h3,
        CSS_OP_SUB_WITH_BORROW = 4'h4,
        CSS_OP_NIBBLE_SWAP = 4'h5,
        CSS_OP_LOAD_DIRECTION_REG = 4'h6,
        CSS_OP_XOR_LITERAL = 4'h7,
        CSS_OP_XOR_FILE = 4'h8
    } css_op_e;

    // Status flags, bit order as in the status register
    typedef struct packed {
        logic timeout_flag;
        logic powerdown_flag;
        logic zero_flag;
        logic digit_carry_flag;
        logic carry_flag;
    } css_flags_s;

    // Port direction registers
    typedef struct packed {
        logic [7:0] port_a_direction;
        logic [7:0] port_b_direction;
        logic [7:0] port_c_direction;
    } css_dir_s;
endpackage

// ===== css_exec.sv
// Execution slice: subtract, nibble swap, direction load, exclusive OR, power-down
`timescale 1ns/1ns
module css_exec
    import css_pkg::*;
#(
    parameter int WDOG_W = 8,
    parameter int PRESCALE_W = 8
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [css_pkg::CSS_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output css_pkg::css_flags_s flags_out,
    output css_pkg::css_dir_s dir_out,
    output logic [7:0] acc_out,
    output logic [WDOG_W-1:0] wdog_count_out
);
    import css_pkg::*;

    // Held state
    logic [7:0] acc_r;
    css_flags_s flags_r;
    css_dir_s dir_r;
    logic [7:0] file_mem [CSS_FILE_DEPTH];
    logic [WDOG_W-1:0] wdog_r;
    logic [PRESCALE_W-1:0] prescale_r;
    logic [16:0] cmd_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    // Bus decode nets
    logic setup_ph;
    logic wr_acc;
    logic is_file;
    logic [6:0] file_idx;
    logic hit_cmd;
    logic hit_acc;
    logic hit_status;
    logic hit_dir_a;
    logic hit_dir_b;
    logic hit_dir_c;
    logic hit_wdog;
    logic mapped;

    // Instruction datapath nets
    css_op_e op;
    logic [7:0] arg;
    logic dest;
    logic exec;
    logic [7:0] file_val;
    logic [7:0] sub_a;
    logic cin;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [7:0] result;
    logic wr_result;
    logic res_to_file;
    logic upd_cdc;
    logic upd_z;

    // APB decode; no wait state, read data comes from flip-flops loaded in the setup cycle
    assign setup_ph = psel_in & ~penable_in;
    assign pready_out = psel_in & penable_in;
    assign wr_acc = pready_out & pwrite_in;
    assign is_file = (paddr_in[11:9] == CSS_FILE_PAGE) && (paddr_in[1:0] == 2'h0);
    assign file_idx = paddr_in[8:2];
    assign hit_cmd = (paddr_in == CSS_OFS_CMD);
    assign hit_acc = (paddr_in == CSS_OFS_ACC);
    assign hit_status = (paddr_in == CSS_OFS_STATUS);
    assign hit_dir_a = (paddr_in == CSS_OFS_DIR_A);
    assign hit_dir_b = (paddr_in == CSS_OFS_DIR_B);
    assign hit_dir_c = (paddr_in == CSS_OFS_DIR_C);
    assign hit_wdog = (paddr_in == CSS_OFS_WDOG);
    assign mapped = hit_cmd | hit_acc | hit_status | hit_dir_a | hit_dir_b | hit_dir_c | hit_wdog | is_file;

    // A write to the command word executes one instruction
    assign op = css_op_e'(pwdata_in[CSS_CMD_OP_LSB +: 4]);
    assign arg = pwdata_in[CSS_CMD_ARG_LSB +: 8];
    assign dest = pwdata_in[CSS_CMD_DEST_BIT];
    assign exec = wr_acc & hit_cmd;
    assign file_val = file_mem[arg[6:0]];

    // Shared subtractor: a + ~acc + cin, carry out means no borrow
    always_comb begin
        sub_a = file_val;
        cin = 1'b1;
        if (op == CSS_OP_SUB_ACC_FROM_LITERAL) begin
            sub_a = arg;
        end
        if (op == CSS_OP_SUB_WITH_BORROW) begin
            cin = flags_r.carry_flag;
        end
        sum9 = {1'b0, sub_a} + {1'b0, ~acc_r} + {8'h00, cin};
        nib5 = {1'b0, sub_a[3:0]} + {1'b0, ~acc_r[3:0]} + {4'h0, cin};
    end

    // Result select and routing per operation
    always_comb begin
        result = 8'h00;
        wr_result = 1'b0;
        res_to_file = 1'b0;
        upd_cdc = 1'b0;
        upd_z = 1'b0;
        unique case (op)
            CSS_OP_SUB_ACC_FROM_LITERAL: begin
                result = sum9[7:0];
                wr_result = 1'b1;
                upd_cdc = 1'b1;
                upd_z = 1'b1;
            end
            CSS_OP_SUB_ACC_FROM_FILE, CSS_OP_SUB_WITH_BORROW: begin
                result = sum9[7:0];
                wr_result = 1'b1;
                res_to_file = dest;
                upd_cdc = 1'b1;
                upd_z = 1'b1;
            end
            CSS_OP_NIBBLE_SWAP: begin
                result = {file_val[3:0], file_val[7:4]};
                wr_result = 1'b1;
                res_to_file = dest;
            end
            CSS_OP_XOR_LITERAL: begin
                result = acc_r ^ arg;
                wr_result = 1'b1;
                upd_z = 1'b1;
            end
            CSS_OP_XOR_FILE: begin
                result = acc_r ^ file_val;
                wr_result = 1'b1;
                res_to_file = dest;
                upd_z = 1'b1;
            end
            CSS_OP_NOP, CSS_OP_ENTER_POWERDOWN, CSS_OP_LOAD_DIRECTION_REG: begin
                result = 8'h00;
            end
            default: begin
                result = 8'h00; // Unused codes act as no-operation
            end
        endcase
    end

    // Accumulator
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc_r <= CSS_RST_ACC;
        end else if (exec && wr_result && !res_to_file) begin
            acc_r <= result;
        end else if (wr_acc && hit_acc) begin
            acc_r <= pwdata_in[7:0];
        end
    end

    // File register array
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < CSS_FILE_DEPTH; i++) begin
                file_mem[i] <= CSS_RST_FILE;
            end
        end else if (exec && wr_result && res_to_file) begin
            file_mem[arg[6:0]] <= result;
        end else if (wr_acc && is_file) begin
            file_mem[file_idx] <= pwdata_in[7:0];
        end
    end

    // Status flags
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flags_r <= css_flags_s'(CSS_RST_STATUS);
        end else if (exec) begin
            // Power-down leaves carry, digit carry and zero alone
            if (op == CSS_OP_ENTER_POWERDOWN) begin
                flags_r.timeout_flag <= 1'b1;
                flags_r.powerdown_flag <= 1'b0;
            end
            if (upd_cdc) begin
                flags_r.carry_flag <= sum9[8];
                flags_r.digit_carry_flag <= nib5[4];
            end
            if (upd_z) begin
                flags_r.zero_flag <= (result == 8'h00);
            end
        end else if (wr_acc && hit_status) begin
            flags_r <= css_flags_s'(pwdata_in[4:0]);
        end
    end

    // Port direction registers
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dir_r <= {CSS_RST_DIR, CSS_RST_DIR, CSS_RST_DIR};
        end else if (exec && op == CSS_OP_LOAD_DIRECTION_REG) begin
            if (arg == CSS_DIR_SEL_A) begin
                dir_r.port_a_direction <= acc_r;
            end
            if (arg == CSS_DIR_SEL_B) begin
                dir_r.port_b_direction <= acc_r;
            end
            if (arg == CSS_DIR_SEL_C) begin
                dir_r.port_c_direction <= acc_r;
            end
        end else if (wr_acc) begin
            if (hit_dir_a) begin
                dir_r.port_a_direction <= pwdata_in[7:0];
            end
            if (hit_dir_b) begin
                dir_r.port_b_direction <= pwdata_in[7:0];
            end
            if (hit_dir_c) begin
                dir_r.port_c_direction <= pwdata_in[7:0];
            end
        end
    end

    // Free-running watchdog: prescaler wrap advances the counter
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wdog_r <= WDOG_W'(CSS_WDOG_CLEAR);
            prescale_r <= PRESCALE_W'(CSS_PRESCALE_CLEAR);
        end else if (exec && op == CSS_OP_ENTER_POWERDOWN) begin
            wdog_r <= WDOG_W'(CSS_WDOG_CLEAR);
            prescale_r <= PRESCALE_W'(CSS_PRESCALE_CLEAR);
        end else begin
            // Counter steps once per full prescaler turn
            prescale_r <= prescale_r + PRESCALE_W'(1);
            if (&prescale_r) begin
                wdog_r <= wdog_r + WDOG_W'(1);
            end
        end
    end

    // Last command word, kept for read-back
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_r <= 17'h00000;
        end else if (exec) begin
            cmd_r <= pwdata_in[16:0];
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            pslverr_r <= ~mapped;
            prdata_r <= 32'h00000000;
            if (!pwrite_in) begin
                if (hit_cmd) begin
                    prdata_r <= {15'h0000, cmd_r};
                end
                if (hit_acc) begin
                    prdata_r <= {24'h000000, acc_r};
                end
                if (hit_status) begin
                    prdata_r <= {27'h0000000, flags_r};
                end
                if (hit_dir_a) begin
                    prdata_r <= {24'h000000, dir_r.port_a_direction};
                end
                if (hit_dir_b) begin
                    prdata_r <= {24'h000000, dir_r.port_b_direction};
                end
                if (hit_dir_c) begin
                    prdata_r <= {24'h000000, dir_r.port_c_direction};
                end
                // Prescaler in bits 15:8, counter in the low byte
                if (hit_wdog) begin
                    prdata_r <= 32'({prescale_r, 8'h00}) | 32'(wdog_r);
                end
                if (is_file) begin
                    prdata_r <= {24'h000000, file_mem[file_idx]};
                end
            end
        end
    end

    // Outputs
    assign prdata_out = prdata_r;
    assign pslverr_out = pready_out & pslverr_r;
    assign flags_out = flags_r;
    assign dir_out = dir_r;
    assign acc_out = acc_r;
    assign wdog_count_out = wdog_r;
endmodule

// ===== css_exec_chk.sv
// Assertion checker for the execution slice, bound to its ports
`timescale 1ns/1ns
module css_exec_chk
    import css_pkg::*;
#(
    parameter int WDOG_W = 8
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [css_pkg::CSS_ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire css_pkg::css_flags_s flags_out,
    input wire css_pkg::css_dir_s dir_out,
    input wire logic [7:0] acc_out,
    input wire logic [WDOG_W-1:0] wdog_count_out
);
    logic cmd_w;
    logic [3:0] op;
    logic [7:0] k;
    // Command write taken at this edge, with its fields
    assign cmd_w = psel_in & penable_in & pwrite_in & (paddr_in == CSS_OFS_CMD);
    assign op = pwdata_in[3:0];
    assign k = pwdata_in[15:8];
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    property p_sleep;
        cmd_w && op == 4'h1 |=> flags_out.timeout_flag && !flags_out.powerdown_flag
            && flags_out[2:0] == $past(flags_out[2:0]);
    endproperty
    a_sleep: assert property (p_sleep) else $error("power-down flags wrong");
    property p_wdog;
        cmd_w && op == 4'h1 |=> wdog_count_out == '0 [*2];
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog not cleared");
    property p_lit;
        cmd_w && op == 4'h2 |=> acc_out == 8'($past(k) - $past(acc_out));
    endproperty
    a_lit: assert property (p_lit) else $error("literal subtract wrong");
    property p_litc;
        cmd_w && op == 4'h2 |=> flags_out.carry_flag == ($past(acc_out) <= $past(k))
            && flags_out.digit_carry_flag == ($past(acc_out[3:0]) <= $past(k[3:0]));
    endproperty
    a_litc: assert property (p_litc) else $error("literal subtract carries wrong");
    property p_fzero;
        cmd_w && op == 4'h3 && !pwdata_in[16] |=> flags_out.zero_flag == (acc_out == 8'h00);
    endproperty
    a_fzero: assert property (p_fzero) else $error("zero flag wrong");
    property p_swap;
        cmd_w && op == 4'h5 |=> $stable(flags_out);
    endproperty
    a_swap: assert property (p_swap) else $error("swap touched flags");
    property p_dir;
        cmd_w && op == 4'h6 && k == 8'h05 |=> dir_out.port_a_direction == $past(acc_out) && $stable(flags_out);
    endproperty
    a_dir: assert property (p_dir) else $error("direction load wrong");
    property p_xorl;
        cmd_w && op == 4'h7 |=> acc_out == ($past(acc_out) ^ $past(k))
            && flags_out[1:0] == $past(flags_out[1:0]) && flags_out.zero_flag == (acc_out == 8'h00);
    endproperty
    a_xorl: assert property (p_xorl) else $error("literal xor wrong");
    property p_xorf;
        cmd_w && op == 4'h8 && pwdata_in[16] |=> $stable(acc_out) && flags_out[1:0] == $past(flags_out[1:0]);
    endproperty
    a_xorf: assert property (p_xorf) else $error("file xor wrong");
endmodule

bind css_exec css_exec_chk #(.WDOG_W(WDOG_W)) u_chk (.clk_in, .rstn_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .flags_out, .dir_out, .acc_out, .wdog_count_out);

// ===== cpu_subtract_swap_xor_ops_tb.sv
// Self-checking testbench for the execution slice
`timescale 1ns/1ns
module cpu_subtract_swap_xor_ops_tb;
    import css_pkg::*;
    logic clk_in = 0, rstn_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, dst = 0;
    logic [11:0] paddr_in = '0;
    logic [31:0] pwdata_in = '0, prdata_out, rq;
    logic pready_out, pslverr_out, re;
    css_flags_s flags_out;
    css_dir_s dir_out;
    logic [7:0] acc_out, wdog_count_out, m_acc, a, k, fv;
    logic [7:0] m_file [128];
    logic [7:0] m_dir [3];
    logic [4:0] m_st;
    logic [3:0] op;
    int num_errors = 0, num_checks = 0, seed = 32'hddcefce1;

    css_exec u_dut (.clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .prdata_out, .pready_out, .pslverr_out, .flags_out, .dir_out, .acc_out, .wdog_count_out);

    // Clock, 4 ns period
    always #2 clk_in = ~clk_in;

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (e !== g) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // One APB transfer, then an idle edge
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int t;
        psel_in <= 1;
        penable_in <= 0;
        pwrite_in <= w;
        paddr_in <= ad;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1;
        t = 0;
        do begin
            @(posedge clk_in);
            t++;
        end while (pready_out !== 1'b1 && t < 20);
        if (t >= 20) num_errors++;
        rq = prdata_out;
        re = pslverr_out;
        psel_in <= 0;
        penable_in <= 0;
        @(posedge clk_in);
    endtask

    // Reference model of one command
    task automatic model();
        int v, vn, b;
        logic [7:0] f, r;
        f = m_file[k[6:0]];
        r = m_acc;
        b = (op == 4) ? !m_st[0] : 0;
        v = int'(op == 2 ? k : f) - int'(m_acc) - b;
        vn = int'(op == 2 ? k[3:0] : f[3:0]) - int'(m_acc[3:0]) - b;
        case (op)
            1: m_st[4:3] = 2'b10;
            2, 3, 4: begin
                r = v[7:0];
                m_st[2:0] = {r == 0, vn >= 0, v >= 0};
            end
            5: r = {f[3:0], f[7:4]};
            6: if (k >= 5 && k <= 7) m_dir[k - 5] = m_acc;
            7, 8: begin
                r = m_acc ^ (op == 7 ? k : f);
                m_st[2] = (r == 0);
            end
            default: ;
        endcase
        if (op == 2 || op == 7 || (op inside {3, 4, 5, 8} && !dst)) m_acc = r;
        else if (op inside {3, 4, 5, 8}) m_file[k[6:0]] = r;
    endtask

    task automatic close_out();
        if (num_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog against a hung bus
    initial begin
        #40000;
        num_errors++;
        close_out();
    end

    // Main sequence: reset, unmapped access, every command with random operands
    initial begin
        repeat (20) @(posedge clk_in);
        rstn_in <= 1;
        @(posedge clk_in);
        chk("flags", CSS_RST_STATUS, flags_out);
        chk("dirs", {3{CSS_RST_DIR}}, dir_out);
        m_dir = '{CSS_RST_DIR, CSS_RST_DIR, CSS_RST_DIR};
        apb(0, 12'h100, 0);
        chk("error", 1, re);
        chk("rdata", 0, rq);
        for (int i = 0; i < 64; i++) begin
            op = 4'(i % 10); // Codes 0 and 9 exercise the no-operation decode
            a = 8'($random(seed));
            fv = (i % 3 == 0) ? a : 8'($random(seed));
            k = (op == 6) ? 8'(4 + (i / 8) % 4) : (i % 3 == 0 && op inside {2, 7}) ? a : 8'($random(seed));
            dst = i[3];
            m_acc = a;
            m_file[k[6:0]] = fv;
            m_st = 5'($random(seed));
            apb(1, CSS_OFS_ACC, {24'h0, a});
            apb(1, CSS_OFS_FILE_BASE + 12'(4 * k[6:0]), {24'h0, fv});
            apb(1, CSS_OFS_STATUS, {27'h0, m_st});
            if (op == 1) repeat (260) @(posedge clk_in); // Let the watchdog step before it is cleared
            apb(1, CSS_OFS_CMD, {15'h0, dst, k, 4'h0, op});
            model();
            chk("acc", m_acc, acc_out);
            chk("flags", m_st, flags_out);
            chk("dirs", {m_dir[0], m_dir[1], m_dir[2]}, dir_out);
            if (op == 1) chk("wdog", 0, wdog_count_out);
            apb(0, CSS_OFS_FILE_BASE + 12'(4 * k[6:0]), 0);
            chk("file", m_file[k[6:0]], rq);
        end
        close_out();
    end
endmodule
